// [interrupt_vector_fetch_bridge_tb.sv]
// Self-checking testbench for the vector fetch bridge
`timescale 1ns/10ps
module interrupt_vector_fetch_bridge_tb;
  import vector_bridge_pkg::*;
  localparam logic [15:0] DEST = 16'h0042;
  logic clk_in = 1'b0, rst_in = 1'b1, fetch_cmd_in = 1'b0, bus_event_valid_in = 1'b0;
  logic [3:0] peripheral_bus_request_in = 4'h0, sys_interrupt_out, peripheral_bus_grant_out;
  logic [1:0] fetch_level_in = 2'h0, mode = 2'h0;
  logic [15:0] master_id_in = 16'h0000, vec = 16'h0000, periph_data_in;
  logic [4:0] bus_event_code_in = 5'h00;
  logic selection_acknowledge_in, vector_valid_strobe_in, peripheral_bus_busy_in;
  logic slave_sync_strobe_out, reply_valid_out, selection_acknowledge_timeout_out, fetch_abort_out;
  logic [31:0] reply_data_out, d;
  logic [2:0] reply_status_out;
  logic [3:0] g;
  logic [1:0] s;
  int err_count = 0;
  int total_checks = 0;

  always #2.5 clk_in = ~clk_in;

  vector_fetch_bridge dut_u (.clk_in, .rst_in, .peripheral_bus_request_in, .sys_interrupt_out,
    .fetch_cmd_in, .fetch_level_in, .master_id_in, .dest_id_in(DEST),
    .vector_offset_in(16'h0005), .bus_event_valid_in, .bus_event_code_in,
    .peripheral_bus_grant_out, .selection_acknowledge_in, .vector_valid_strobe_in,
    .peripheral_bus_busy_in, .periph_data_in, .slave_sync_strobe_out, .reply_valid_out,
    .reply_data_out, .reply_status_out, .selection_acknowledge_timeout_out, .fetch_abort_out);

  periph_device_model model_u (.clk_in, .grant_in(peripheral_bus_grant_out),
    .slave_sync_in(slave_sync_strobe_out), .mode_in(mode), .vec_in(vec),
    .ack_out(selection_acknowledge_in), .strobe_out(vector_valid_strobe_in),
    .busy_out(peripheral_bus_busy_in), .data_out(periph_data_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic issue(input logic [1:0] l, input logic [15:0] id);
    fetch_cmd_in = 1'b1;
    fetch_level_in = l;
    master_id_in = id;
    @(negedge clk_in);
    fetch_cmd_in = 1'b0;
  endtask

  task automatic send_event(input logic [4:0] code);
    bus_event_valid_in = 1'b1;
    bus_event_code_in = code;
    @(negedge clk_in);
    bus_event_valid_in = 1'b0;
  endtask

  // Full fetch; collects grant, slave sync and timeout seen up to and including the reply cycle
  task automatic run_fetch(input logic [1:0] l, m, input logic [15:0] v, input logic [4:0] fin);
    mode = m;
    vec = v;
    g = '0;
    s = '0;
    issue(l, DEST);
    send_event(EV_VECTOR_SELECTED);
    // Grant stands only one cycle, so sample before each wait
    for (int i = 0; i < 40; i++) begin
      g |= peripheral_bus_grant_out;
      s |= {slave_sync_strobe_out, selection_acknowledge_timeout_out};
      if (reply_valid_out === 1'b1) break;
      @(negedge clk_in);
    end
    d = reply_data_out;
    chk(reply_valid_out, 1'b1);
    chk(reply_status_out, STATUS_READ_DATA);
    send_event(fin);
    chk(reply_valid_out, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_request();
    peripheral_bus_request_in = 4'hF;
    @(negedge clk_in);
    chk(sys_interrupt_out, 4'h0);
    peripheral_bus_request_in = 4'h0;
    @(negedge clk_in);
    chk(sys_interrupt_out, 4'hF);
  endtask

  task automatic t_reject();
    g = '0;
    s = '0;
    issue(2'd1, DEST ^ 16'h0001);
    send_event(EV_VECTOR_SELECTED);
    repeat (4) begin
      @(negedge clk_in);
      g |= peripheral_bus_grant_out | {3'h0, reply_valid_out};
    end
    chk(g, 4'h0);
    issue(2'd1, DEST);
    send_event(EV_ARB_LOST);
    // Abort pulse is already up when the event task returns
    repeat (3) begin
      g |= peripheral_bus_grant_out;
      s |= {1'b0, fetch_abort_out};
      @(negedge clk_in);
    end
    chk(s, 2'b01);
    chk(g, 4'h0);
  endtask

  task automatic t_paths();
    run_fetch(2'd1, 2'd0, 16'h1230, EV_ACK_NONERROR);
    chk(d, 32'h00001235);
    chk(g, 4'h2);
    chk(s, 2'b10);
    run_fetch(2'd2, 2'd1, 16'hBEEF, EV_ACK_NONERROR);
    chk(d, 32'h00000005);
    chk(s, 2'b01);
    run_fetch(2'd3, 2'd2, 16'hBEEF, EV_ACK_NONERROR);
    chk(d, 32'h00000000);
    chk(s, 2'b00);
    chk(g, 4'h8);
  endtask

  task automatic t_retry();
    run_fetch(2'd0, 2'd0, 16'hA5A0, EV_ILLEGAL_CONFIRM);
    chk(d, 32'h0000A5A5);
    repeat (2) @(negedge clk_in);
    chk(sys_interrupt_out, 4'h1);
    run_fetch(2'd0, 2'd0, 16'h0F00, EV_ACK_NONERROR);
    chk(d, 32'h0000A5A5);
    chk(g, 4'h0);
    repeat (2) @(negedge clk_in);
    chk(sys_interrupt_out, 4'h0);
    // Nothing pending at this level now, so a fetch must be ignored
    g = '0;
    issue(2'd0, DEST);
    send_event(EV_VECTOR_SELECTED);
    repeat (4) begin
      g |= peripheral_bus_grant_out | {3'h0, reply_valid_out};
      @(negedge clk_in);
    end
    chk(g, 4'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    t_request();
    t_reject();
    t_paths();
    t_retry();
    finish_test();
  end

  // Whole run is under a hundred 5 ns cycles; the 5000 ns limit leaves ample margin
  initial begin
    #5000;
    err_count++;
    finish_test();
  end
endmodule

// [periph_device_model.sv]
// Behavioural peripheral device that answers grants from the bridge
`timescale 1ns/10ps
module periph_device_model
  import vector_bridge_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic [LEVELS-1:0] grant_in,
  input  wire logic              slave_sync_in,
  input  wire logic [1:0]        mode_in,
  input  wire logic [VEC_W-1:0]  vec_in,
  output logic                   ack_out,
  output logic                   strobe_out,
  output logic                   busy_out,
  output logic      [VEC_W-1:0]  data_out
);
  // Mode 0 answers, mode 1 never answers, mode 2 releases passively
  initial begin
    ack_out = 1'b0;
    strobe_out = 1'b0;
    busy_out = 1'b0;
    data_out = 16'hFFFF;
    forever begin
      @(negedge clk_in);
      // Released data lines keep changing so a stale vector cannot pass
      data_out = ~data_out;
      if (|grant_in) begin
        ack_out = 1'b1;
        busy_out = 1'b1;
        wait (grant_in == '0);
        @(negedge clk_in);
        if (mode_in == 2'd0) begin
          data_out = vec_in;
          strobe_out = 1'b1;
          @(negedge clk_in);
          ack_out = 1'b0;
          wait (slave_sync_in);
          @(negedge clk_in);
          strobe_out = 1'b0;
          busy_out = 1'b0;
        end else begin
          ack_out = 1'b0;
          busy_out = (mode_in == 2'd1);
          @(negedge clk_in);
          busy_out = 1'b0;
        end
      end
    end
  end
endmodule

// [vector_fetch_bridge.sv]
// Forwards peripheral interrupts to the system bus and services vector fetches
`timescale 1ns/10ps
module vector_fetch_bridge
  import vector_bridge_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [LEVELS-1:0] peripheral_bus_request_in,
  output logic      [LEVELS-1:0] sys_interrupt_out,
  input  wire logic              fetch_cmd_in,
  input  wire logic [LVL_W-1:0]  fetch_level_in,
  input  wire logic [ID_W-1:0]   master_id_in,
  input  wire logic [ID_W-1:0]   dest_id_in,
  input  wire logic [VEC_W-1:0]  vector_offset_in,
  input  wire logic              bus_event_valid_in,
  input  wire logic [EV_W-1:0]   bus_event_code_in,
  output logic      [LEVELS-1:0] peripheral_bus_grant_out,
  input  wire logic              selection_acknowledge_in,
  input  wire logic              vector_valid_strobe_in,
  input  wire logic              peripheral_bus_busy_in,
  input  wire logic [VEC_W-1:0]  periph_data_in,
  output logic                   slave_sync_strobe_out,
  output logic                   reply_valid_out,
  output logic      [DATA_W-1:0] reply_data_out,
  output logic      [STAT_W-1:0] reply_status_out,
  output logic                   selection_acknowledge_timeout_out,
  output logic                   fetch_abort_out
);
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_CHECK   = 3'h1,
    ST_GRANT   = 3'h2,
    ST_COLLECT = 3'h3,
    ST_SYNC    = 3'h4,
    ST_REPLY   = 3'h5
  } state_t;

  state_t            state_reg, state_next;
  logic [LVL_W-1:0]  lvl_reg, lvl_next;
  logic [VEC_W-1:0]  vec_reg, vec_next;
  logic [VEC_W-1:0]  final_reg, final_next;
  logic              vector_valid_strobe_seen_reg, vector_valid_strobe_seen_next;
  logic [LEVELS-1:0] pending_reg, pending_next;
  logic [LEVELS-1:0] vector_valid_strobe_reg, vector_valid_strobe_next;
  logic [LEVELS-1:0] grant_reg, grant_next;
  logic              slave_sync_strobe_reg, slave_sync_strobe_next;
  logic              timeout_reg, timeout_next;
  logic              abort_reg, abort_next;
  logic              reply_valid_reg, reply_valid_next;
  logic [STAT_W-1:0] status_reg, status_next;
  logic              slot_wr, slot_clr, slot_valid;
  logic [VEC_W-1:0]  slot_data;
  logic [LEVELS-1:0] slot_valid_all;
  logic              ev_selected, ev_arb_lost, ev_ack, ev_illegal;

  function automatic logic ev_is(input logic vld, input logic [EV_W-1:0] code,
                                 input logic [EV_W-1:0] want);
    return vld && (code == want);
  endfunction

  assign ev_selected = ev_is(bus_event_valid_in, bus_event_code_in, EV_VECTOR_SELECTED);
  assign ev_arb_lost = ev_is(bus_event_valid_in, bus_event_code_in, EV_ARB_LOST);
  assign ev_ack = ev_is(bus_event_valid_in, bus_event_code_in, EV_ACK_NONERROR);
  assign ev_illegal = ev_is(bus_event_valid_in, bus_event_code_in, EV_ILLEGAL_CONFIRM);

  vector_slot #(
    .NLEV (LEVELS),
    .LW   (LVL_W),
    .VW   (VEC_W)
  ) u_slot (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .wr_en_in      (slot_wr),
    .clr_en_in     (slot_clr),
    .lvl_in        (lvl_reg),
    .wr_data_in    (final_reg),
    .rd_valid_out  (slot_valid),
    .rd_data_out   (slot_data),
    .valid_all_out (slot_valid_all)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    lvl_next = lvl_reg;
    vec_next = vec_reg;
    final_next = final_reg;
    vector_valid_strobe_seen_next = vector_valid_strobe_seen_reg;
    grant_next = grant_reg;
    slave_sync_strobe_next = slave_sync_strobe_reg;
    timeout_next = 1'b0;
    abort_next = 1'b0;
    slot_wr = 1'b0;
    slot_clr = 1'b0;
    pending_next = pending_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (fetch_cmd_in && (pending_reg[fetch_level_in] || slot_valid_all[fetch_level_in])
            && (master_id_in == dest_id_in)) begin
          lvl_next = fetch_level_in;
          state_next = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (ev_arb_lost) begin
          abort_next = 1'b1;
          state_next = ST_IDLE;
        end else if (ev_selected) begin
          if (slot_valid) begin
            final_next = slot_data;
            state_next = ST_REPLY;
          end else begin
            grant_next = '0;
            grant_next[lvl_reg] = 1'b1;
            state_next = ST_GRANT;
          end
        end
      end
      ST_GRANT: begin
        vector_valid_strobe_seen_next = 1'b0;
        if (selection_acknowledge_in) begin
          grant_next = '0;
          state_next = ST_COLLECT;
        end
      end
      ST_COLLECT: begin
        if (vector_valid_strobe_in && !vector_valid_strobe_seen_reg) begin
          vector_valid_strobe_seen_next = 1'b1;
          vec_next = periph_data_in;
        end
        if (!selection_acknowledge_in) begin
          if (vector_valid_strobe_seen_reg) begin
            slave_sync_strobe_next = 1'b1;
            state_next = ST_SYNC;
          end else if (!peripheral_bus_busy_in) begin
            vec_next = VEC_ZERO;
            final_next = VEC_ZERO;
            state_next = ST_REPLY;
          end else begin
            timeout_next = 1'b1;
            vec_next = VEC_ZERO;
            final_next = VEC_ZERO | vector_offset_in;
            state_next = ST_REPLY;
          end
        end
      end
      ST_SYNC: begin
        // Slave sync is held until the peripheral lets go of its strobe
        if (!vector_valid_strobe_in) begin
          slave_sync_strobe_next = 1'b0;
          final_next = vec_reg | vector_offset_in;
          state_next = ST_REPLY;
        end
      end
      ST_REPLY: begin
        if (ev_ack) begin
          slot_clr = 1'b1;
          pending_next[lvl_reg] = 1'b0;
          state_next = ST_IDLE;
        end else if (ev_illegal) begin
          slot_wr = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // A request arriving as the level clears must not be lost
    pending_next = pending_next | peripheral_bus_request_in;
    vector_valid_strobe_next = pending_reg | slot_valid_all;
    // Reply flags track the next state so the outputs come from flops
    reply_valid_next = (state_next == ST_REPLY);
    status_next = reply_valid_next ? STATUS_READ_DATA : '0;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
      lvl_reg <= '0;
      vec_reg <= '0;
      final_reg <= '0;
      vector_valid_strobe_seen_reg <= 1'b0;
      pending_reg <= '0;
      vector_valid_strobe_reg <= '0;
      grant_reg <= '0;
      slave_sync_strobe_reg <= 1'b0;
      timeout_reg <= 1'b0;
      abort_reg <= 1'b0;
      reply_valid_reg <= 1'b0;
      status_reg <= '0;
    end else begin
      state_reg <= state_next;
      lvl_reg <= lvl_next;
      vec_reg <= vec_next;
      final_reg <= final_next;
      vector_valid_strobe_seen_reg <= vector_valid_strobe_seen_next;
      pending_reg <= pending_next;
      vector_valid_strobe_reg <= vector_valid_strobe_next;
      grant_reg <= grant_next;
      slave_sync_strobe_reg <= slave_sync_strobe_next;
      timeout_reg <= timeout_next;
      abort_reg <= abort_next;
      reply_valid_reg <= reply_valid_next;
      status_reg <= status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reply fields come from registers only, so the bus sees no glitching data
  assign sys_interrupt_out = vector_valid_strobe_reg;
  assign peripheral_bus_grant_out = grant_reg;
  assign slave_sync_strobe_out = slave_sync_strobe_reg;
  assign reply_valid_out = reply_valid_reg;
  assign reply_data_out = {{(DATA_W-VEC_W){1'b0}}, final_reg};
  assign reply_status_out = status_reg;
  assign selection_acknowledge_timeout_out = timeout_reg;
  assign fetch_abort_out = abort_reg;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_vector_valid_strobe_follows_req: assert property (
    peripheral_bus_request_in[0] |-> ##2 sys_interrupt_out[0])
    else $error("request did not raise interrupt");
  a_fetch_id_match: assert property (
    (state_reg == ST_IDLE && fetch_cmd_in && master_id_in != dest_id_in) |=> state_reg == ST_IDLE)
    else $error("fetch accepted with wrong id");
  a_grant_after_select: assert property (
    $rose(|peripheral_bus_grant_out) |-> $past(ev_selected) && $past(state_reg == ST_CHECK))
    else $error("grant without selection");
  a_no_grant_failed: assert property (
    (state_reg == ST_CHECK && ev_selected && slot_valid)
      |=> grant_reg == '0 && state_reg == ST_REPLY)
    else $error("grant issued despite stored vector");
  a_grant_level: assert property (
    (state_reg == ST_CHECK && ev_selected && !slot_valid && !ev_arb_lost)
      |=> peripheral_bus_grant_out == (4'h1 << lvl_reg))
    else $error("wrong grant level");
  a_slave_sync_strobe_after_both: assert property (
    $rose(slave_sync_strobe_out) |-> $past(vector_valid_strobe_seen_reg) && !$past(selection_acknowledge_in))
    else $error("slave sync too early");
  a_timeout_zero: assert property (
    (state_reg == ST_COLLECT && !selection_acknowledge_in && !vector_valid_strobe_seen_reg
      && peripheral_bus_busy_in) |=> selection_acknowledge_timeout_out && vec_reg == 16'h0000 ##1 !selection_acknowledge_timeout_out)
    else $error("timeout not flagged with zero vector");
  a_passive_release: assert property (
    (state_reg == ST_COLLECT && !selection_acknowledge_in && !vector_valid_strobe_seen_reg
      && !peripheral_bus_busy_in) |=> !selection_acknowledge_timeout_out && reply_data_out == 32'h0000_0000)
    else $error("passive release mishandled");
  a_vector_or: assert property (
    (state_reg == ST_SYNC && !vector_valid_strobe_in)
      |=> final_reg == ($past(vec_reg) | $past(vector_offset_in)))
    else $error("offset not ORed");
  a_reply_status: assert property (
    reply_valid_out |-> reply_status_out == STATUS_READ_DATA && reply_data_out[15:0] == final_reg)
    else $error("bad reply");
  a_ack_to_idle: assert property (
    (state_reg == ST_REPLY && ev_ack) |=> state_reg == ST_IDLE && !reply_valid_out)
    else $error("ack did not end fetch");
  a_failed_stored: assert property (
    (state_reg == ST_REPLY && ev_illegal && !ev_ack)
      |=> slot_valid && slot_data == $past(final_reg))
    else $error("failed vector not stored");
  a_level_cleared: assert property (
    (state_reg == ST_REPLY && ev_ack && !peripheral_bus_request_in[lvl_reg])
      |=> !pending_reg[lvl_reg] && !slot_valid)
    else $error("level not cleared after delivery");
endmodule

// [vector_slot.sv]
// Shared constants and the per-level store for vectors whose delivery failed
`timescale 1ns/10ps
package vector_bridge_pkg;
  localparam int LEVELS = 4;
  localparam int LVL_W = 2;
  localparam int VEC_W = 16;
  localparam int ID_W = 16;
  localparam int EV_W = 5;
  localparam int DATA_W = 32;
  localparam int STAT_W = 3;
  localparam logic [EV_W-1:0] EV_VECTOR_SELECTED = 5'h01;
  localparam logic [EV_W-1:0] EV_ARB_LOST = 5'h02;
  localparam logic [EV_W-1:0] EV_ACK_NONERROR = 5'h03;
  localparam logic [EV_W-1:0] EV_ILLEGAL_CONFIRM = 5'h04;
  localparam logic [STAT_W-1:0] STATUS_READ_DATA = 3'h4;
  localparam logic [VEC_W-1:0] VEC_ZERO = 16'h0000;
endpackage

module vector_slot
  import vector_bridge_pkg::*;
#(
  parameter int NLEV = LEVELS,
  parameter int LW   = LVL_W,
  parameter int VW   = VEC_W
) (
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          wr_en_in,
  input  wire logic          clr_en_in,
  input  wire logic [LW-1:0] lvl_in,
  input  wire logic [VW-1:0] wr_data_in,
  output logic               rd_valid_out,
  output logic [VW-1:0]      rd_data_out,
  output logic [NLEV-1:0]    valid_all_out
);
  logic [NLEV-1:0] valid_reg;
  logic [NLEV-1:0] valid_next;
  logic [VW-1:0]   data_reg [NLEV];
  logic [VW-1:0]   data_next [NLEV];

  always_comb begin
    valid_next = valid_reg;
    data_next = data_reg;
    if (clr_en_in) begin
      valid_next[lvl_in] = 1'b0;
    end
    if (wr_en_in) begin
      valid_next[lvl_in] = 1'b1;
      data_next[lvl_in] = wr_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid_reg <= '0;
      for (int i = 0; i < NLEV; i++) begin
        data_reg[i] <= '0;
      end
    end else begin
      valid_reg <= valid_next;
      data_reg <= data_next;
    end
  end

  assign rd_valid_out = valid_reg[lvl_in];
  assign rd_data_out = data_reg[lvl_in];
  assign valid_all_out = valid_reg;
endmodule
